// [include/adcc_pkg.sv]
// Shared constants and types of the converter control block
package adcc_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] ADCC_OFF_SCR = 5'h00; // Status/control
    localparam logic [4:0] ADCC_OFF_RHI = 5'h04; // Result high
    localparam logic [4:0] ADCC_OFF_RLO = 5'h08; // Result low
    localparam logic [4:0] ADCC_OFF_CLK = 5'h0C; // Converter clock register

    // ----------------------------------------------------------------
    // Status/control fields and reset values
    // ----------------------------------------------------------------
    localparam int ADCC_SCR_DONE = 7; // Conversion done flag
    localparam int ADCC_SCR_IEN = 6; // Interrupt enable
    localparam int ADCC_SCR_CONT = 5; // Continuous mode
    localparam int ADCC_SCR_CH_HI = 4; // Channel field top bit
    localparam logic [4:0] ADCC_CH_OFF = 5'h1F; // Power-down code
    localparam logic [7:0] ADCC_SCR_RST = 8'h1F;

    // ----------------------------------------------------------------
    // Clock register fields and reset value
    // ----------------------------------------------------------------
    localparam int ADCC_CLK_MODE_LO = 2; // Resolution mode, two bits
    localparam int ADCC_CLK_LSMP = 1; // Long sample select
    localparam int ADCC_CLK_ACLK = 0; // Async clock enable
    localparam logic [7:0] ADCC_CLK_RST = 8'h00;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        ADCC_IDLE = 1'b0,
        ADCC_CONV = 1'b1
    } adcc_state_t;

    // Request bundle towards the analog converter core
    typedef struct packed {
        logic start; // One-cycle start pulse
        logic abort; // One-cycle abort pulse
        logic powerDown; // Core in low-power state
        logic isolate; // Input isolated from the pad
        logic longSample; // Long sample time
        logic tenBit; // Ten-bit resolution
        logic [4:0] chan; // Selected input
    } adcc_core_req_t;
endpackage

// [hdl/adcc_chan_decode.sv]
// Channel code decoder of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_chan_decode
    import adcc_pkg::*;
(
    // Code in
    input wire logic [4:0] chan,
    // Decoded class
    output logic chanOff,
    output logic chanUnused
);
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // Inputs 0-7, 24, 25, bandgap and both references are real sources;
    // every other code except the off code 1F still converts but yields an undefined value.
    always_comb begin
        chanOff = (chan == ADCC_CH_OFF);
        case (chan)
            5'h18, 5'h19, 5'h1A, 5'h1D, 5'h1E, 5'h1F: chanUnused = 1'b0;
            default: chanUnused = (chan[4:3] != 2'h0);
        endcase
    end
endmodule
`default_nettype wire

// [hdl/adcc_result.sv]
// Result register pair with high/low read interlock
`timescale 1ns/1ps
`default_nettype none
module adcc_result
    import adcc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Load side
    input wire logic load,
    input wire logic [9:0] data,
    input wire logic tenBit,
    // Software read events
    input wire logic readHigh,
    input wire logic readLow,
    // Register values
    output logic [7:0] resHigh,
    output logic [7:0] resLow
);
    logic locked; // High half read, low half not yet

    // ----------------------------------------------------------------
    // Interlock
    // ----------------------------------------------------------------
    // Only in ten-bit mode; results arriving while locked are dropped
    always_ff @(posedge mclk) begin
        if (rst) begin
            locked <= 1'b0;
        end else if (readLow) begin
            locked <= 1'b0;
        end else if (readHigh && tenBit) begin
            locked <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Result storage
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            resHigh <= 8'h00;
            resLow <= 8'h00;
        end else if (load && !(locked && tenBit)) begin
            resHigh <= tenBit ? {6'h00, data[9:8]} : 8'h00;
            resLow <= tenBit ? data[7:0] : data[9:2];
        end
    end
endmodule
`default_nettype wire

// [hdl/adcc_ctrl.sv]
// Converter control: registers, conversion sequencing, flag and request
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Control write aborts and restarts unless powered off
// - Done flag read-only, set on each completion
// - Control write or low read clears done
// - Interrupt on completion only when enabled
// - Low result read or control write withdraws interrupt
// - Continuous mode converts back to back
// - Reset, stop without async clock, clock write, control write end continuous
// - After stop, only a control write restarts
// - Continuous write aborts and starts new run
// - Single mode: one conversion per write
// - Five-bit channel code selects input
// - All-ones code powers off and isolates input
// - All-ones write starts no extra conversion
// - Low power automatically after a single or final conversion
// - Unused codes convert, result undefined
// - Break clear-enable set: clears during break stick
// - Break clear-enable clear: break access keeps flags
// - Second clearing step after break clears flag
// - No hardware trigger; software starts only
// - Done flag sets regardless of interrupt enable
// - Ten-bit high read locks results until low read
// - Async clock on: conversions continue in stop
module adcc_ctrl
    import adcc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // System state
    input wire logic stopMode,
    input wire logic debugBreak,
    input wire logic breakClearEnable,
    // Converter core
    input wire logic coreDone,
    input wire logic [9:0] coreData,
    output adcc_core_req_t coreReq,
    output logic convIrq
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] scr; // Status/control, done bit unused here
    logic [7:0] clkReg; // Converter clock register
    logic doneFlag; // Conversion done
    logic contRun; // Continuous run active
    adcc_state_t state; // Sequencer state
    logic commit; // Bus access takes effect this edge
    logic wrScr, wrClk, rdHigh, rdLow; // Access events
    logic flagClrOk; // Flag clearing permitted
    logic finish; // Core finished a live conversion
    logic stopHalt; // Stop without async clock
    logic wrOff, curOff, curUnused; // Channel classes
    logic [7:0] resHigh, resLow; // Result values
    logic tenBit; // Ten-bit resolution selected

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Effect lands only on the edge where waitrequest is seen low
    assign commit = !avs_waitrequest;
    assign wrScr = commit && avs_write && avs_byteenable[0] && avs_address == ADCC_OFF_SCR;
    assign wrClk = commit && avs_write && avs_byteenable[0] && avs_address == ADCC_OFF_CLK;
    assign rdHigh = commit && avs_read && avs_address == ADCC_OFF_RHI;
    assign rdLow = commit && avs_read && avs_address == ADCC_OFF_RLO;
    // Break protection of flags
    assign flagClrOk = !debugBreak || breakClearEnable;
    assign finish = (state == ADCC_CONV) && coreDone;
    // Async clock keeps the sequencer alive in stop
    assign stopHalt = stopMode && !clkReg[ADCC_CLK_ACLK];
    assign tenBit = clkReg[ADCC_CLK_MODE_LO];

    // Channel classes of the written and the held code
    adcc_chan_decode uWrDec (
        .chan(avs_writedata[ADCC_SCR_CH_HI:0]),
        .chanOff(wrOff),
        .chanUnused()
    );
    adcc_chan_decode uCurDec (
        .chan(scr[ADCC_SCR_CH_HI:0]),
        .chanOff(curOff),
        .chanUnused(curUnused)
    );

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    // One wait state: low for one cycle after a request is seen
    always_ff @(posedge mclk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    // Read data captured in the wait cycle, stable at the commit edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            case (avs_address)
                ADCC_OFF_SCR: avs_readdata <= {24'h00_0000, doneFlag, scr[6:0]};
                ADCC_OFF_RHI: avs_readdata <= {24'h00_0000, resHigh};
                ADCC_OFF_RLO: avs_readdata <= {24'h00_0000, resLow};
                ADCC_OFF_CLK: avs_readdata <= {24'h00_0000, clkReg};
                default: avs_readdata <= 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Control fields; the done bit is hardware-owned
    always_ff @(posedge mclk) begin
        if (rst) begin
            scr <= ADCC_SCR_RST;
        end else if (wrScr) begin
            scr <= {1'b0, avs_writedata[6:0]};
        end
    end

    // Clock register holds mode, sample length and async enable
    always_ff @(posedge mclk) begin
        if (rst) begin
            clkReg <= ADCC_CLK_RST;
        end else if (wrClk) begin
            clkReg <= avs_writedata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Done flag
    // ----------------------------------------------------------------
    // Set wins over a clear in the same cycle so no completion is lost
    always_ff @(posedge mclk) begin
        if (rst) begin
            doneFlag <= 1'b0;
        end else if (finish) begin
            doneFlag <= 1'b1;
        end else if ((wrScr || rdLow) && flagClrOk) begin
            doneFlag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt request
    // ----------------------------------------------------------------
    // Follows enable AND flag, so clearing the flag withdraws it
    always_ff @(posedge mclk) begin
        if (rst) begin
            convIrq <= 1'b0;
        end else begin
            convIrq <= scr[ADCC_SCR_IEN] && doneFlag;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Only register writes start work; there is no trigger pin, and the
    // hardware-trigger mode code behaves as a software mode here.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ADCC_IDLE;
            contRun <= 1'b0;
        end else if (wrScr) begin
            if (wrOff) begin
                state <= ADCC_IDLE;
                contRun <= 1'b0;
            end else begin
                state <= ADCC_CONV;
                contRun <= avs_writedata[ADCC_SCR_CONT];
            end
        end else if (stopHalt) begin
            state <= ADCC_IDLE;
            contRun <= 1'b0;
        end else begin
            if (wrClk) begin
                contRun <= 1'b0;
            end
            case (state)
                ADCC_IDLE: state <= ADCC_IDLE;
                ADCC_CONV: begin
                    if (coreDone && !(contRun && !wrClk)) begin
                        state <= ADCC_IDLE;
                    end
                end
                default: state <= ADCC_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Core request
    // ----------------------------------------------------------------
    // Abort and start may pulse together: abort the old, then start
    always_ff @(posedge mclk) begin
        if (rst) begin
            coreReq <= '{start: 1'b0, abort: 1'b0, powerDown: 1'b1,
                isolate: 1'b1, longSample: 1'b0, tenBit: 1'b0, chan: ADCC_CH_OFF};
        end else begin
            coreReq.start <= (wrScr && !wrOff)
                || (finish && contRun && !wrClk && !stopHalt && !wrScr);
            coreReq.abort <= (state == ADCC_CONV) && !coreDone
                && (wrScr || stopHalt);
            coreReq.powerDown <= (state == ADCC_IDLE);
            coreReq.isolate <= curOff;
            coreReq.longSample <= clkReg[ADCC_CLK_LSMP];
            coreReq.tenBit <= tenBit;
            coreReq.chan <= scr[ADCC_SCR_CH_HI:0];
        end
    end

    // ----------------------------------------------------------------
    // Results
    // ----------------------------------------------------------------
    adcc_result uRes (
        .mclk(mclk),
        .rst(rst),
        .load(finish),
        .data(coreData),
        .tenBit(tenBit),
        .readHigh(rdHigh),
        .readLow(rdLow),
        .resHigh(resHigh),
        .resLow(resLow)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_WR_STARTS: assert property (wrScr && !wrOff |=> coreReq.start && state == ADCC_CONV)
        else $error("control write did not start a conversion");
    AST_OFF_NOSTART: assert property (wrScr && wrOff |=> !coreReq.start ##1 coreReq.powerDown)
        else $error("power-off write started a conversion");
    AST_DONE_SET: assert property (finish |=> doneFlag)
        else $error("done flag not set at completion");
    AST_WR_CLEAR: assert property (wrScr && flagClrOk && !finish |=> !doneFlag)
        else $error("control write did not clear done flag");
    AST_BRK_HOLD: assert property (debugBreak && !breakClearEnable && doneFlag |=> doneFlag)
        else $error("done flag changed during protected break");
    AST_IRQ_FOLLOW: assert property (finish && scr[ADCC_SCR_IEN] && !wrScr |=> ##1 convIrq)
        else $error("interrupt missing after enabled completion");
    AST_IRQ_MASK: assert property (!scr[ADCC_SCR_IEN] |=> !convIrq)
        else $error("interrupt raised while disabled");
    AST_CONT_NEXT: assert property (finish && contRun && !wrScr && !wrClk && !stopHalt
        |=> coreReq.start && state == ADCC_CONV)
        else $error("continuous run did not restart");
    AST_SINGLE_END: assert property (finish && !contRun && !wrScr |=> state == ADCC_IDLE)
        else $error("single conversion did not end");
    AST_STOP_HALT: assert property (stopHalt && !wrScr |=> state == ADCC_IDLE && !contRun)
        else $error("stop without async clock left converter running");
    AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    COV_SINGLE: cover property (wrScr && !wrOff ##[1:50] finish);
    COV_CONT: cover property (finish && contRun ##[1:50] finish);
    COV_BREAK: cover property (debugBreak && rdLow && doneFlag);
    COV_UNUSED: cover property (wrScr && !wrOff ##1 curUnused);
endmodule
`default_nettype wire

// [tb/adcc_testbench.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import adcc_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic mclk; // Bus clock
    logic rst; // Sync reset
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic stopMode; // MCU stop state
    logic debugBreak; // Break state
    logic breakClearEnable; // Break clear-enable bit
    logic coreDone; // Core finish pulse
    logic [9:0] coreData; // Core result
    adcc_core_req_t coreReq;
    logic convIrq;
    int mismatches = 0; // Failed checks
    int compares = 0; // All checks
    int cycles = 0; // Timeout counter
    logic seenStart; // Start pulse seen in window
    logic seenAbort; // Abort pulse seen in window
    logic [7:0] rd; // Last read byte

    adcc_ctrl dut (
        .mclk(mclk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .stopMode(stopMode), .debugBreak(debugBreak),
        .breakClearEnable(breakClearEnable),
        .coreDone(coreDone), .coreData(coreData), .coreReq(coreReq), .convIrq(convIrq)
    );

    // ------------------------------------------------------------
    // Clock and timeout
    // ------------------------------------------------------------
    // Bus clock stays the fastest clock of the bench
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Whole run is a few hundred cycles; ceiling well above that
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge mclk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        check("waitrequest", 8'h00, {7'h00, avs_waitrequest});
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [4:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(name, exp, rd);
    endtask

    // Watches the one-cycle core pulses for n cycles
    task automatic watch(input int n);
        seenStart = 1'b0;
        seenAbort = 1'b0;
        repeat (n) begin
            #1;
            if (coreReq.start === 1'b1) seenStart = 1'b1;
            if (coreReq.abort === 1'b1) seenAbort = 1'b1;
            @(posedge mclk);
        end
    endtask

    // Completion pulse from the core, data valid with it
    task automatic done_pulse(input logic [9:0] d);
        @(posedge mclk);
        coreDone <= 1'b1;
        coreData <= d;
        @(posedge mclk);
        coreDone <= 1'b0;
    endtask

    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        stopMode = 1'b0;
        debugBreak = 1'b0;
        breakClearEnable = 1'b0;
        coreDone = 1'b0;
        coreData = 10'h000;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        // Reset state: powered down, no request
        check("powerDown", 8'h01, {7'h00, coreReq.powerDown});
        check("irq", 8'h00, {7'h00, convIrq});
        rdchk("ctrl", ADCC_OFF_SCR, ADCC_SCR_RST);
        rdchk("clkreg", ADCC_OFF_CLK, 8'h00);
        rdchk("unmapped", 5'h10, 8'h00);
        // Off code with done bit written: no conversion, flag stays low
        bus(1'b1, ADCC_OFF_SCR, 8'h9F);
        watch(6);
        check("start", 8'h00, {7'h00, seenStart});
        rdchk("ctrl", ADCC_OFF_SCR, 8'h1F);
        check("isolate", 8'h01, {7'h00, coreReq.isolate});
        // Single conversion, interrupt enabled, eight-bit result
        bus(1'b1, ADCC_OFF_SCR, 8'h43);
        watch(4);
        check("start", 8'h01, {7'h00, seenStart});
        check("chan", 8'h03, {3'h0, coreReq.chan});
        check("powerDown", 8'h00, {7'h00, coreReq.powerDown});
        done_pulse(10'h2A5);
        watch(4);
        check("start", 8'h00, {7'h00, seenStart});
        rdchk("ctrl", ADCC_OFF_SCR, 8'hC3);
        check("irq", 8'h01, {7'h00, convIrq});
        check("powerDown", 8'h01, {7'h00, coreReq.powerDown});
        rdchk("high", ADCC_OFF_RHI, 8'h00);
        rdchk("low", ADCC_OFF_RLO, 8'hA9);
        // Flag clears at the commit edge, the request one edge later
        watch(2);
        check("irq", 8'h00, {7'h00, convIrq});
        rdchk("ctrl", ADCC_OFF_SCR, 8'h43);
        // Interrupt disabled: flag sets, request stays low
        bus(1'b1, ADCC_OFF_SCR, 8'h05);
        watch(4);
        done_pulse(10'h100);
        watch(4);
        check("irq", 8'h00, {7'h00, convIrq});
        rdchk("ctrl", ADCC_OFF_SCR, 8'h85);
        // Control write withdraws a pending request
        bus(1'b1, ADCC_OFF_SCR, 8'h45);
        watch(4);
        done_pulse(10'h100);
        watch(4);
        check("irq", 8'h01, {7'h00, convIrq});
        bus(1'b1, ADCC_OFF_SCR, 8'h5F);
        watch(4);
        check("irq", 8'h00, {7'h00, convIrq});
        rdchk("ctrl", ADCC_OFF_SCR, 8'h5F);
        // Continuous run, then re-armed mid-conversion
        bus(1'b1, ADCC_OFF_SCR, 8'h20);
        watch(4);
        done_pulse(10'h004);
        watch(3);
        check("start", 8'h01, {7'h00, seenStart});
        rdchk("low", ADCC_OFF_RLO, 8'h01);
        bus(1'b1, ADCC_OFF_SCR, 8'h21);
        watch(4);
        check("abort", 8'h01, {7'h00, seenAbort});
        check("start", 8'h01, {7'h00, seenStart});
        // Clock register write ends the run; ten-bit mode from here
        bus(1'b1, ADCC_OFF_CLK, 8'h04);
        done_pulse(10'h3C5);
        watch(6);
        check("start", 8'h00, {7'h00, seenStart});
        rdchk("clkreg", ADCC_OFF_CLK, 8'h04);
        rdchk("high", ADCC_OFF_RHI, 8'h03);
        // High read locks out the next result until low is read
        bus(1'b1, ADCC_OFF_SCR, 8'h02);
        watch(4);
        done_pulse(10'h111);
        watch(4);
        rdchk("low", ADCC_OFF_RLO, 8'hC5);
        bus(1'b1, ADCC_OFF_SCR, 8'h02);
        watch(4);
        done_pulse(10'h2F0);
        watch(4);
        rdchk("high", ADCC_OFF_RHI, 8'h02);
        rdchk("low", ADCC_OFF_RLO, 8'hF0);
        // Stop with async clock off aborts; no restart on wake
        bus(1'b1, ADCC_OFF_SCR, 8'h20);
        watch(4);
        @(posedge mclk);
        stopMode <= 1'b1;
        watch(4);
        check("abort", 8'h01, {7'h00, seenAbort});
        stopMode <= 1'b0;
        watch(10);
        check("start", 8'h00, {7'h00, seenStart});
        bus(1'b1, ADCC_OFF_SCR, 8'h20);
        watch(4);
        check("start", 8'h01, {7'h00, seenStart});
        // Async clock on: conversion completes inside stop
        bus(1'b1, ADCC_OFF_CLK, 8'h05);
        bus(1'b1, ADCC_OFF_SCR, 8'h40);
        watch(4);
        stopMode <= 1'b1;
        done_pulse(10'h0AA);
        watch(4);
        check("irq", 8'h01, {7'h00, convIrq});
        stopMode <= 1'b0;
        // Break with clear-enable low keeps the flag
        debugBreak <= 1'b1;
        rdchk("low", ADCC_OFF_RLO, 8'hAA);
        rdchk("ctrl", ADCC_OFF_SCR, 8'hC0);
        // Clear-enable high: cleared in break stays cleared
        breakClearEnable <= 1'b1;
        rdchk("low", ADCC_OFF_RLO, 8'hAA);
        debugBreak <= 1'b0;
        breakClearEnable <= 1'b0;
        rdchk("ctrl", ADCC_OFF_SCR, 8'h40);
        stop_test();
    end
endmodule
`default_nettype wire
